// ### eesi_top.sv
// Purpose: EEPROM serial interface, two-pin and three-wire modes
// Assumes: Register strobes synchronous to clock
// Notes: Phase 0 of a bit drives the clock low, phase 1 high
`timescale 1ns/1ps
`default_nettype none
`include "eesi_cfg.svh"

// What this block does
// - Two-pin mode uses pins four and five
// - Command 0011 transmits the buffered byte
// - Busy falls at end, raising done interrupt
// - Bit 5 reads 0 on peer acknowledge
// - Command 0001 receives one byte
// - Two-pin clock 78kHz, idle high
// - Illegal command sets error, does nothing
// - Bit 6 is busy during transfer
// - Bit 4 reads 0 after sent acknowledge
// - Clock free-runs after a two-pin byte until a no-op, start, stop or three-wire command
// - Command 0010 receives then acknowledges
// - Codes 0101 stop, 1001 start
// - Select 3 gives 500kHz three-wire mode
// - Three-wire write moves up to 8 bits
// - Wait-ready with float flag holds busy until data rises
// - Float flag releases data at last rise
// - Read-select fills buffer from device
// - Count field sets clocks, 0 to 8
// - MSB first; reads right-justified
// - Zero count gives no clocks: drives or floats data, may wait for ready
module eesi_top (
   input wire logic clock, // System clock
   input wire logic srst, // Synchronous reset, active high
   input wire logic [1:0] eepromPinSelect, // Pin routing select
   input wire logic ctrlWrite, // Write strobe, control register
   input wire logic [7:0] ctrlWdata, // Control write data
   output logic [7:0] ctrlRdata, // Control register read value
   input wire logic bufWrite, // Write strobe, byte buffer
   input wire logic [7:0] bufWdata, // Byte buffer write data
   output logic [7:0] bufRdata, // Byte buffer read value
   output logic serialDoneInterrupt, // One-cycle pulse at busy fall
   output logic gpioPinFourOut, // Serial clock out
   output logic gpioPinFourOe, // Serial clock enable
   input wire logic gpioPinFiveIn, // Serial data line in
   output logic gpioPinFiveOut, // Serial data line out
   output logic gpioPinFiveOe // Serial data line enable
);
   typedef struct packed {
      eesi_pkg::eesi_state_t state;
      logic [7:0] buffer;
      logic [3:0] bitsLeft;
      logic [7:0] halfCnt;
      logic phase;
      logic readMode;
      logic sendAck;
      logic floatFlag;
      logic waitReady;
      logic threeWire;
      logic error;
      logic busy;
      logic rxAckN;
      logic txAckN;
      logic sck;
      logic sdaOut;
      logic sdaOe;
      logic clockRun;
      logic [1:0] seqStep;
      logic dataPrev;
      logic doneIrq;
   } eesi_regs_t;

   eesi_regs_t cur_ff;
   eesi_regs_t nxt_cur;
   logic [7:0] halfLimit;
   logic halfTick;
   logic threeWireSel;

   assign threeWireSel = (eepromPinSelect == `EESI_SEL_3W);
   assign halfLimit = cur_ff.threeWire ? 8'(`EESI_3W_HALF - 1) : 8'(`EESI_I2C_HALF - 1);
   assign halfTick = (cur_ff.halfCnt == halfLimit);

   always_comb begin
      nxt_cur = cur_ff;
      nxt_cur.doneIrq = 1'b0;
      nxt_cur.dataPrev = gpioPinFiveIn;
      if (cur_ff.state != eesi_pkg::ST_IDLE || cur_ff.clockRun) begin
         nxt_cur.halfCnt = halfTick ? 8'h00 : cur_ff.halfCnt + 8'h01;
      end
      // Free-running clock in two-pin mode until a no-op, start, stop or three-wire command stops it
      if (cur_ff.state == eesi_pkg::ST_IDLE && cur_ff.clockRun && halfTick) begin
         nxt_cur.sck = ~cur_ff.sck;
      end
      unique case (cur_ff.state)
         eesi_pkg::ST_IDLE: begin
            if (ctrlWrite) begin
               nxt_cur.threeWire = threeWireSel;
               nxt_cur.halfCnt = 8'h00;
               nxt_cur.phase = 1'b0;
               nxt_cur.seqStep = 2'h0;
               if (threeWireSel) begin
                  nxt_cur.readMode = ctrlWdata[`EESI_BIT_RD];
                  nxt_cur.floatFlag = ctrlWdata[`EESI_BIT_FLOAT];
                  nxt_cur.waitReady = ctrlWdata[`EESI_BIT_WAITRDY] & ctrlWdata[`EESI_BIT_FLOAT];
                  nxt_cur.bitsLeft = (ctrlWdata[3:0] > `EESI_MAX_COUNT) ? `EESI_MAX_COUNT
                                     : ctrlWdata[3:0];
                  nxt_cur.busy = 1'b1;
                  nxt_cur.sck = 1'b0;
                  nxt_cur.clockRun = 1'b0;
                  if (ctrlWdata[3:0] == 4'h0) begin
                     nxt_cur.sdaOe = ~ctrlWdata[`EESI_BIT_FLOAT];
                     // A zero-count command may still wait for the ready rise
                     nxt_cur.state = (ctrlWdata[`EESI_BIT_WAITRDY] & ctrlWdata[`EESI_BIT_FLOAT])
                                     ? eesi_pkg::ST_WAIT : eesi_pkg::ST_DONE;
                  end else begin
                     nxt_cur.sdaOe = ~ctrlWdata[`EESI_BIT_RD];
                     nxt_cur.state = eesi_pkg::ST_BIT;
                  end
               end else begin
                  nxt_cur.sendAck = 1'b0;
                  unique case (ctrlWdata[3:0])
                     `EESI_CMD_NOP: begin
                        nxt_cur.clockRun = 1'b0;
                        nxt_cur.sck = 1'b1;
                     end
                     `EESI_CMD_TX: begin
                        nxt_cur.readMode = 1'b0;
                        nxt_cur.bitsLeft = 4'h8;
                        nxt_cur.busy = 1'b1;
                        nxt_cur.sck = 1'b0;
                        nxt_cur.sdaOe = 1'b1;
                        nxt_cur.state = eesi_pkg::ST_BIT;
                     end
                     `EESI_CMD_RX, `EESI_CMD_RXACK: begin
                        nxt_cur.readMode = 1'b1;
                        nxt_cur.sendAck = (ctrlWdata[3:0] == `EESI_CMD_RXACK);
                        nxt_cur.bitsLeft = 4'h8;
                        nxt_cur.busy = 1'b1;
                        nxt_cur.sck = 1'b0;
                        nxt_cur.sdaOe = 1'b0;
                        nxt_cur.state = eesi_pkg::ST_BIT;
                     end
                     `EESI_CMD_STOP: begin
                        nxt_cur.busy = 1'b1;
                        nxt_cur.state = eesi_pkg::ST_STOP;
                     end
                     `EESI_CMD_START: begin
                        nxt_cur.busy = 1'b1;
                        nxt_cur.state = eesi_pkg::ST_START;
                     end
                     `EESI_CMD_RSVD: begin
                     end
                     default: begin
                        nxt_cur.error = 1'b1;
                     end
                  endcase
                  if (ctrlWdata[3:0] == `EESI_CMD_NOP || ctrlWdata[3:0] == `EESI_CMD_RSVD
                      || ctrlWdata[3:0] == `EESI_CMD_START || ctrlWdata[3:0] == `EESI_CMD_STOP
                      || ctrlWdata[3:0] == `EESI_CMD_TX || ctrlWdata[3:0] == `EESI_CMD_RX
                      || ctrlWdata[3:0] == `EESI_CMD_RXACK) begin
                     nxt_cur.error = 1'b0;
                  end
               end
            end else if (bufWrite) begin
               nxt_cur.buffer = bufWdata;
            end
         end
         eesi_pkg::ST_START: begin
            // Clock high, data falls while clock is high
            if (halfTick) begin
               nxt_cur.seqStep = cur_ff.seqStep + 2'h1;
               unique case (cur_ff.seqStep)
                  2'h0: begin
                     nxt_cur.sck = 1'b1;
                     nxt_cur.sdaOe = 1'b0;
                  end
                  2'h1: nxt_cur.sdaOe = 1'b1;
                  2'h2: nxt_cur.sck = 1'b0;
                  2'h3: begin
                     nxt_cur.clockRun = 1'b0;
                     nxt_cur.state = eesi_pkg::ST_DONE;
                  end
               endcase
            end
         end
         eesi_pkg::ST_STOP: begin
            // Data low, clock rises, then data released high
            if (halfTick) begin
               nxt_cur.seqStep = cur_ff.seqStep + 2'h1;
               unique case (cur_ff.seqStep)
                  2'h0: begin
                     nxt_cur.sck = 1'b0;
                     nxt_cur.sdaOe = 1'b1;
                  end
                  2'h1: nxt_cur.sck = 1'b1;
                  2'h2: nxt_cur.sdaOe = 1'b0;
                  2'h3: begin
                     nxt_cur.clockRun = 1'b0;
                     nxt_cur.state = eesi_pkg::ST_DONE;
                  end
               endcase
            end
         end
         eesi_pkg::ST_BIT: begin
            if (halfTick) begin
               nxt_cur.phase = ~cur_ff.phase;
               nxt_cur.sck = ~cur_ff.phase;
               if (cur_ff.phase) begin
                  // Falling edge: advance bit
                  if (cur_ff.readMode) begin
                     nxt_cur.buffer = {cur_ff.buffer[6:0], gpioPinFiveIn};
                  end else begin
                     nxt_cur.buffer = {cur_ff.buffer[6:0], 1'b0};
                  end
                  nxt_cur.bitsLeft = cur_ff.bitsLeft - 4'h1;
                  if (cur_ff.bitsLeft == 4'h1) begin
                     if (cur_ff.threeWire) begin
                        nxt_cur.sck = 1'b0;
                        nxt_cur.state = cur_ff.waitReady ? eesi_pkg::ST_WAIT
                                                         : eesi_pkg::ST_DONE;
                     end else begin
                        nxt_cur.sdaOe = cur_ff.readMode & cur_ff.sendAck;
                        nxt_cur.state = eesi_pkg::ST_ACK;
                     end
                  end
               end else if (cur_ff.threeWire && cur_ff.floatFlag && cur_ff.bitsLeft == 4'h1) begin
                  nxt_cur.sdaOe = 1'b0;
               end
            end
         end
         eesi_pkg::ST_ACK: begin
            if (halfTick) begin
               nxt_cur.phase = ~cur_ff.phase;
               nxt_cur.sck = ~cur_ff.phase;
               if (!cur_ff.phase && !cur_ff.readMode) begin
                  nxt_cur.rxAckN = gpioPinFiveIn;
               end
               if (cur_ff.phase) begin
                  if (cur_ff.sendAck) begin
                     nxt_cur.txAckN = 1'b0;
                  end
                  nxt_cur.sdaOe = 1'b0;
                  nxt_cur.clockRun = 1'b1;
                  nxt_cur.state = eesi_pkg::ST_DONE;
               end
            end
         end
         eesi_pkg::ST_WAIT: begin
            if (gpioPinFiveIn && !cur_ff.dataPrev) begin
               nxt_cur.state = eesi_pkg::ST_DONE;
            end
         end
         eesi_pkg::ST_DONE: begin
            nxt_cur.busy = 1'b0;
            nxt_cur.doneIrq = 1'b1;
            nxt_cur.state = eesi_pkg::ST_IDLE;
         end
         default: nxt_cur.state = eesi_pkg::ST_IDLE;
      endcase
      if (srst) begin
         nxt_cur = '0;
         nxt_cur.state = eesi_pkg::ST_IDLE;
         nxt_cur.rxAckN = 1'b1;
         nxt_cur.txAckN = 1'b1;
         nxt_cur.sck = 1'b1;
         nxt_cur.dataPrev = 1'b1;
      end
   end

   always_ff @(posedge clock) begin
      cur_ff <= nxt_cur;
   end

   // Three-wire reads right-justify: after count shifts the bits sit low
   assign ctrlRdata = {cur_ff.error, cur_ff.busy, cur_ff.rxAckN, cur_ff.txAckN, 4'h0};
   assign bufRdata = cur_ff.buffer;
   assign serialDoneInterrupt = cur_ff.doneIrq;
   assign gpioPinFourOut = cur_ff.sck;
   assign gpioPinFourOe = 1'b1;
   assign gpioPinFiveOut = cur_ff.threeWire ? cur_ff.buffer[7] : 1'b0;
   assign gpioPinFiveOe = cur_ff.threeWire ? cur_ff.sdaOe
                          : (cur_ff.sdaOe & ~(cur_ff.state == eesi_pkg::ST_BIT
                             && !cur_ff.readMode && cur_ff.buffer[7]));

   a_done_pulse: assert property (@(posedge clock) disable iff (srst)
      $fell(cur_ff.busy) |-> serialDoneInterrupt)
      else $error("Done pulse missing at busy fall");
   a_busy_set: assert property (@(posedge clock) disable iff (srst)
      (cur_ff.state == eesi_pkg::ST_IDLE && ctrlWrite && !threeWireSel
       && ctrlWdata[3:0] == `EESI_CMD_TX) |=> cur_ff.busy)
      else $error("Transmit did not set busy");
   a_error_set: assert property (@(posedge clock) disable iff (srst)
      (cur_ff.state == eesi_pkg::ST_IDLE && ctrlWrite && !threeWireSel
       && ctrlWdata[3:0] == 4'h7) |=> (cur_ff.error && !cur_ff.busy))
      else $error("Illegal command not flagged");
   a_wait_hold: assert property (@(posedge clock) disable iff (srst)
      (cur_ff.state == eesi_pkg::ST_WAIT && !gpioPinFiveIn) |=> cur_ff.busy)
      else $error("Busy fell before data rose");
   a_zero_count: assert property (@(posedge clock) disable iff (srst)
      (cur_ff.state == eesi_pkg::ST_IDLE && ctrlWrite && threeWireSel
       && ctrlWdata[3:0] == 4'h0 && !(ctrlWdata[7] && ctrlWdata[5]))
      |=> ##1 (!cur_ff.busy && gpioPinFourOut == 1'b0))
      else $error("Zero count issued clocks");
   a_irq_busy: assert property (@(posedge clock) disable iff (srst)
      serialDoneInterrupt |-> !cur_ff.busy)
      else $error("Interrupt while busy");
endmodule : eesi_top
`default_nettype wire

// ### eesi_cfg.svh
// Purpose: Constants for the EEPROM serial interface
// Assumes: 25 MHz system clock
// Notes: Timing counts derived from rates
`ifndef EESI_CFG_SVH
`define EESI_CFG_SVH
`define EESI_CLK_HZ 25000000
`define EESI_I2C_HZ 78000
`define EESI_3W_HZ 500000
// Half-period counts, rounded down so the rate is never below the figure
`define EESI_I2C_HALF (`EESI_CLK_HZ / (2 * `EESI_I2C_HZ))
`define EESI_3W_HALF (`EESI_CLK_HZ / (2 * `EESI_3W_HZ))
`define EESI_BIT_ERROR 7
`define EESI_BIT_BUSY 6
`define EESI_BIT_RXACK 5
`define EESI_BIT_TXACK 4
`define EESI_BIT_WAITRDY 7
`define EESI_BIT_FLOAT 5
`define EESI_BIT_RD 4
`define EESI_CMD_NOP 4'h0
`define EESI_CMD_RX 4'h1
`define EESI_CMD_RXACK 4'h2
`define EESI_CMD_TX 4'h3
`define EESI_CMD_STOP 4'h5
`define EESI_CMD_RSVD 4'h6
`define EESI_CMD_START 4'h9
`define EESI_SEL_3W 2'h3
`define EESI_MAX_COUNT 4'h8
`endif

// ### eesi_pkg.sv
// Purpose: Types for the EEPROM serial interface
// Assumes: Nothing
// Notes: States of both modes; start, stop and ack are two-pin only, wait is three-wire only
package eesi_pkg;
   typedef enum logic [3:0] {
      ST_IDLE, ST_START, ST_STOP, ST_BIT, ST_ACK, ST_WAIT, ST_DONE
   } eesi_state_t;
endpackage : eesi_pkg

// ### eesi_eeprom_model.sv
// Purpose: Stand-in for the serial EEPROM on the data line
// Assumes: Data line has a pull-up; the model only ever pulls it low
// Notes: Bit slots are counted on serial clock falls within a frame
`timescale 1ns/1ps
`default_nettype none
module eesi_eeprom_model (
   input wire logic sck, // Serial clock from the block
   input wire logic frameSel, // Low reloads the slot count: 0 if idleLow, else F
   input wire logic sendMode, // 1 sends sendByte, 0 listens
   input wire logic ackEn, // Acknowledge a received byte
   input wire logic holdLow, // Hold data low while not ready
   input wire logic idleLow, // Clock idles low, first slot starts at select
   input wire logic [7:0] sendByte, // Byte sent MSB first
   output logic pullLow // Pulls the data line low
);
   logic [3:0] slot = 4'hF;
   always @(negedge sck or negedge frameSel) begin
      if (!frameSel) begin
         slot <= idleLow ? 4'h0 : 4'hF;
      end else begin
         slot <= slot + 4'h1;
      end
   end
   always_comb begin
      pullLow = holdLow;
      if (frameSel && sendMode && slot < 4'h8) begin
         pullLow = holdLow | ~sendByte[3'h7 - slot[2:0]];
      end
      if (frameSel && !sendMode && ackEn && slot == 4'h8) begin
         pullLow = 1'b1;
      end
   end
endmodule : eesi_eeprom_model
`default_nettype wire

// ### eesi_top_tb_top.sv
// Purpose: Self-checking bench for the EEPROM serial interface
// Assumes: 25 MHz clock, EEPROM model on the data line
// Notes: Inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
`include "eesi_cfg.svh"
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin fail_count++; \
   $display("wrong value %s expected %0h seen %0h", nm, e, g); end end
module eesi_top_tb_top;
   logic clock = 1'b0;
   logic srst = 1'b1;
   logic [1:0] pinSel = 2'h0;
   logic ctrlWrite = 1'b0, bufWrite = 1'b0;
   logic [7:0] ctrlWdata = 8'h00, bufWdata = 8'h00, sendByte = 8'h00;
   logic frameSel = 1'b0, sendMode = 1'b0, ackEn = 1'b0, holdLow = 1'b0;
   logic [7:0] ctrlRdata, bufRdata;
   logic [8:0] cap;
   logic irq, sckOut, dOut, dOe, pullLow, line, prevSck;
   logic sawStart = 1'b0, sawStop = 1'b0;
   int fail_count = 0, n_compared = 0, perCnt = 0, period = 0, rises = 0, waited;
   always #20 clock = ~clock;
   assign line = ~pullLow & (dOe ? dOut : 1'b1);
   eesi_top dut (.clock(clock), .srst(srst), .eepromPinSelect(pinSel),
      .ctrlWrite(ctrlWrite), .ctrlWdata(ctrlWdata), .ctrlRdata(ctrlRdata),
      .bufWrite(bufWrite), .bufWdata(bufWdata), .bufRdata(bufRdata),
      .serialDoneInterrupt(irq), .gpioPinFourOut(sckOut), .gpioPinFourOe(),
      .gpioPinFiveIn(line), .gpioPinFiveOut(dOut), .gpioPinFiveOe(dOe));
   eesi_eeprom_model mem (.sck(sckOut), .frameSel(frameSel), .sendMode(sendMode),
      .ackEn(ackEn), .holdLow(holdLow), .idleLow(pinSel == 2'h3), .sendByte(sendByte),
      .pullLow(pullLow));
   always @(posedge sckOut) cap <= {cap[7:0], line};
   always @(negedge line) if (sckOut === 1'b1) sawStart = 1'b1;
   always @(posedge line) if (sckOut === 1'b1) sawStop = 1'b1;
   always @(posedge clock) begin
      prevSck <= sckOut;
      perCnt <= perCnt + 1;
      if (sckOut === 1'b1 && prevSck === 1'b0) begin
         period <= perCnt + 1;
         perCnt <= 0;
         rises <= rises + 1;
      end
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask : tick
   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict
   task automatic writeCtrl(input logic [7:0] v);
      ctrlWrite = 1'b1;
      ctrlWdata = v;
      tick(1);
      ctrlWrite = 1'b0;
   endtask : writeCtrl
   task automatic writeBuf(input logic [7:0] v);
      bufWrite = 1'b1;
      bufWdata = v;
      tick(1);
      bufWrite = 1'b0;
   endtask : writeBuf
   task automatic waitDone();
      for (waited = 0; waited < 6000 && irq !== 1'b1; waited++) tick(1);
      if (waited == 6000) begin
         fail_count++;
         print_verdict();
      end
      `CHK("busy at done", 1'b0, ctrlRdata[6])
      tick(1);
   endtask : waitDone
   // Each command is issued, then waited on until it finishes
   task automatic runCmd(input logic [7:0] v);
      writeCtrl(v);
      waitDone();
   endtask : runCmd
   task automatic t_reset();
      `CHK("ctrl reset", 8'h30, ctrlRdata & 8'hF0)
      `CHK("clock idle", 1'b1, sckOut)
      `CHK("irq idle", 1'b0, irq)
      writeCtrl(8'h07);
      tick(3);
      `CHK("bad code", 2'h2, ctrlRdata[7:6])
      $display("test reset and illegal code done");
   endtask : t_reset
   task automatic t_tx();
      int lows;
      writeBuf(8'hA5);
      {frameSel, sendMode, ackEn} = 3'b101;
      writeCtrl(8'h03);
      tick(1);
      `CHK("busy", 1'b1, ctrlRdata[6])
      waitDone();
      `CHK("sent bits", 9'h14A, cap)
      `CHK("peer ack", 1'b0, ctrlRdata[5])
      `CHK("error cleared", 1'b0, ctrlRdata[7])
      `CHK("i2c period", 2 * `EESI_I2C_HALF, period)
      frameSel = 1'b0;
      lows = 0;
      for (int i = 0; i < 400; i++) begin
         tick(1);
         lows += (sckOut === 1'b0);
      end
      `CHK("clock runs", 1'b1, lows > 0)
      writeCtrl(8'h00);
      tick(400);
      lows = 0;
      for (int i = 0; i < 700; i++) begin
         tick(1);
         lows += (sckOut !== 1'b1);
      end
      `CHK("clock stopped", 0, lows)
      $display("test transmit done");
   endtask : t_tx
   task automatic t_rx(input logic [7:0] cmd, input logic [7:0] b);
      {frameSel, sendMode, sendByte} = {2'b11, b};
      runCmd(cmd);
      `CHK("rx byte", b, bufRdata)
      `CHK("sent ack", cmd != 8'h02, ctrlRdata[4])
      frameSel = 1'b0;
      writeCtrl(8'h00);
      tick(700);
      $display("test receive done");
   endtask : t_rx
   task automatic t_startstop();
      sawStart = 1'b0;
      runCmd(8'h09);
      `CHK("start seen", 1'b1, sawStart)
      sawStop = 1'b0;
      runCmd(8'h05);
      `CHK("stop seen", 1'b1, sawStop)
      writeCtrl(8'h00);
      tick(700);
      $display("test start and stop done");
   endtask : t_startstop
   task automatic t_three();
      int r;
      pinSel = 2'h3;
      {sendMode, ackEn} = 2'b00;
      writeBuf(8'hC3);
      frameSel = 1'b1;
      runCmd(8'h08);
      `CHK("3w bits", 8'hC3, cap[7:0])
      `CHK("3w period", 2 * `EESI_3W_HALF, period)
      frameSel = 1'b0;
      tick(1);
      {frameSel, sendMode, sendByte} = {2'b11, 8'hA7};
      runCmd(8'h34);
      `CHK("3w read", 4'hA, bufRdata[3:0])
      `CHK("floated", 1'b0, dOe)
      frameSel = 1'b0;
      r = rises;
      runCmd(8'h00);
      `CHK("no clocks", r, rises)
      `CHK("driven", 1'b1, dOe)
      {frameSel, holdLow} = 2'b11;
      writeCtrl(8'hA0);
      tick(100);
      `CHK("wait ready", 1'b1, ctrlRdata[6])
      holdLow = 1'b0;
      waitDone();
      `CHK("ready wait", 1'b1, waited < 10)
      $display("test three-wire done");
   endtask : t_three
   initial begin
      tick(4);
      srst = 1'b0;
      t_reset();
      t_tx();
      t_rx(8'h01, 8'h5A);
      t_rx(8'h02, 8'h3C);
      t_startstop();
      t_three();
      print_verdict();
   end
endmodule : eesi_top_tb_top
`default_nettype wire
